// file: verilog/tpw_top.sv
// sixteen-bit pwm timer with interrupt mask and flag logic behind an avalon-mm slave
// What this block does
// - compare-A request (vector 4) is flag and mask bit 6 and global enable.
// - compare-B request (vector 5) is flag and mask bit 5 and global enable.
// - capture pin event sets capture flag; request (vector 3) gated by bit 3.
// - timer-0 overflow request (vector 7) gated by mask bit 1 and global enable.
// - mask bits 4, 2 and 0 are reserved and always read zero.
// - one shared temporary byte stages the high byte of wide accesses.
// - in pwm mode the counter runs up from zero to top and back down.
// - 8, 9 and 10 bit resolutions with tops 00ff, 01ff, 03ff; two channels.
// - each channel compares the counter with its low ten compare bits.
// - modes 00/01 disconnect; 10 clears up, sets down; 11 the inverse.
// - compare writes land in a hold copy that becomes active at top, or on the next edge while stopped.
// - timer-1 overflow request (vector 6) gated by mask bit 7 and global enable.
`timescale 1ns/1ps
`include "tpw_defines.svh"

module tpw_top
#(
  parameter int CMP_BITS = 10
)
(
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire tpw_pkg::tpw_bus_req_t bus_req,
  output tpw_pkg::tpw_bus_rsp_t   bus_rsp,
  input  wire logic               global_irq_enable,
  input  wire logic               capture_input_pin,
  input  wire logic               t0_overflow_event,
  output tpw_pkg::tpw_irq_t       irq_req,
  output logic                    irq,
  output logic                    pwm_out_a,
  output logic                    pwm_out_a_oe,
  output logic                    pwm_out_b,
  output logic                    pwm_out_b_oe
);
  import tpw_pkg::*;

  tpw_state_t    state;
  tpw_state_t    next_state;
  tpw_res_t      res;
  logic [15:0]   top;
  logic          run;
  logic          at_top;
  logic          match_a;
  logic          match_b;
  logic          req;
  logic          accept;
  logic          commit;
  logic [7:0]    wbyte;
  logic [7:0]    rbyte;
  logic [7:0]    events;
  logic [7:0]    w1c;
  logic [7:0]    pend;

  // the channel compare width is tied to the pwm resolutions this block offers:
  // a wider compare would let a match fire at counts the counter never reaches,
  // a narrower one would lose the top bits of the ten-bit mode
  // the check below reports an error at the start of simulation; the channel is still built,
  // so a width that drops bits does not pass unnoticed
  initial
  begin
    if (CMP_BITS != 10)
      $error("tpw_top: only ten compare bits are supported");
  end

  // resolution code zero stops the counter and leaves both pins undriven;
  // any other code runs the counter on every clock, there is no prescaler
  // at_top is the only moment a running timer's channels load a new compare value,
  // so it is qualified by run to keep a stopped timer from looking at top
  assign res    = tpw_res_t'(state.control[`TPW_CTRL_RES_LSB +: 2]);
  assign run    = (res != TPW_RES_OFF);
  assign at_top = run && (state.count == top);

  // request taken on the first cycle, write committed when waitrequest is seen low
  assign req    = bus_req.read || bus_req.write;
  assign accept = req && state.rsp.waitrequest;
  assign commit = req && !state.rsp.waitrequest;
  assign wbyte  = bus_req.writedata[7:0];

  // the stopped code still picks a top so that the compare against the
  // counter never sees an undefined value; it is never used while stopped
  always_comb
  begin
    case (res)
      TPW_RES_8:  top = `TPW_TOP_8;
      TPW_RES_9:  top = `TPW_TOP_9;
      TPW_RES_10: top = `TPW_TOP_10;
      default:    top = `TPW_TOP_10;
    endcase
  end

  // both channels see the same counter and direction, so their periods
  // stay locked; only the compare hold value and the output mode differ
  // a match is reported back to set the flag one edge later, the same
  // edge at which the channel moves its pin
  tpw_chan #(.CMP_BITS(CMP_BITS)) chan_a
  (
    .clock  (clock),
    .reset  (reset),
    .run    (run),
    .at_top (at_top),
    .down   (state.down),
    .count  (state.count),
    .hold   (state.cmp_a),
    .mode   (tpw_out_mode_t'(state.control[`TPW_CTRL_MODE_A_LSB +: 2])),
    .match  (match_a),
    .pin    (pwm_out_a),
    .pin_oe (pwm_out_a_oe)
  );

  tpw_chan #(.CMP_BITS(CMP_BITS)) chan_b
  (
    .clock  (clock),
    .reset  (reset),
    .run    (run),
    .at_top (at_top),
    .down   (state.down),
    .count  (state.count),
    .hold   (state.cmp_b),
    .mode   (tpw_out_mode_t'(state.control[`TPW_CTRL_MODE_B_LSB +: 2])),
    .match  (match_b),
    .pin    (pwm_out_b),
    .pin_oe (pwm_out_b_oe)
  );

  always_comb
  begin
    // high bytes of wide registers always read the staging byte, so a lone
    // high read returns whatever the last low read or high write left there
    // the mask and flag reads hide the reserved bits here as well as on
    // write, so a stray one in a reserved position can never be read back
    case (bus_req.address)
      `TPW_OFS_CONTROL: rbyte = state.control;
      `TPW_OFS_CNT_LO:  rbyte = state.count[7:0];
      `TPW_OFS_CNT_HI:  rbyte = state.temp;
      `TPW_OFS_CMPA_LO: rbyte = state.cmp_a[7:0];
      `TPW_OFS_CMPA_HI: rbyte = state.temp;
      `TPW_OFS_CMPB_LO: rbyte = state.cmp_b[7:0];
      `TPW_OFS_CMPB_HI: rbyte = state.temp;
      `TPW_OFS_MASK:    rbyte = state.mask & `TPW_IRQ_BITS_MASK;
      `TPW_OFS_FLAGS:   rbyte = state.flags & `TPW_IRQ_BITS_MASK;
      default:          rbyte = 8'h00;
    endcase
  end

  always_comb
  begin
    // every event is a single-cycle strobe; the capture edge is found from
    // the previous pin level, which resets low so a pin held high through
    // reset raises the flag once right after release
    // the timer-1 overflow strobe is the down-phase visit of zero only,
    // so it fires once per period and never at the very first count
    events = 8'h00;
    events[`TPW_BIT_CMP_A]   = match_a;
    events[`TPW_BIT_CMP_B]   = match_b;
    events[`TPW_BIT_CAPTURE] = capture_input_pin && !state.capture_prev;
    events[`TPW_BIT_T0_OVF]  = t0_overflow_event;
    events[`TPW_BIT_T1_OVF]  = run && state.down && (state.count == `TPW_BOTTOM);
  end

  // write-one-to-clear acts only at the committing edge so a write that
  // is still waiting for its answer cannot clear a flag early
  assign w1c = (commit && bus_req.write && bus_req.address == `TPW_OFS_FLAGS) ?
               (wbyte & `TPW_IRQ_BITS_MASK) : 8'h00;

  always_comb
  begin
    next_state = state;
    next_state.capture_prev = capture_input_pin;

    // counter: up to top, turn, down to bottom, turn
    if (run)
    begin
      if (!state.down)
      begin
        if (state.count >= top)
        begin
          next_state.down  = 1'b1;
          next_state.count = top - 16'h0001;
        end
        else
          next_state.count = state.count + 16'h0001;
      end
      else
      begin
        if (state.count == `TPW_BOTTOM)
        begin
          next_state.down  = 1'b0;
          next_state.count = 16'h0001;
        end
        else
          next_state.count = state.count - 16'h0001;
      end
    end

    // a hardware event in the clearing cycle survives the clear
    next_state.flags = ((state.flags & ~w1c) | events) & `TPW_IRQ_BITS_MASK;

    // the answer is always exactly one wait cycle long; a fixed latency
    // keeps the read side effect on the staging byte to a single edge even
    // when the master holds its request for the whole access
    // read data is captured at the accepting edge and then held, so the
    // master may sample it at the edge that sees waitrequest low
    // bus answer: one wait cycle, then waitrequest low for the committing edge
    next_state.rsp.waitrequest = 1'b1;
    if (accept)
    begin
      next_state.rsp.waitrequest = 1'b0;
      next_state.rsp.readdata    = {24'h000000, rbyte};
      if (bus_req.read)
      begin
        // reading a low byte stages its high byte for the following high read
        case (bus_req.address)
          `TPW_OFS_CNT_LO:  next_state.temp = state.count[15:8];
          `TPW_OFS_CMPA_LO: next_state.temp = state.cmp_a[15:8];
          `TPW_OFS_CMPB_LO: next_state.temp = state.cmp_b[15:8];
          default:          next_state.temp = state.temp;
        endcase
      end
    end

    // register writes land at the committing edge; a compare write while
    // running only reaches the hold copy, the channel decides when it is used
    // a counter write overrides the counting step of the same cycle and
    // restarts the up phase when zero is written
    if (commit && bus_req.write)
    begin
      case (bus_req.address)
        `TPW_OFS_CONTROL: next_state.control = wbyte;
        `TPW_OFS_CNT_HI,
        `TPW_OFS_CMPA_HI,
        `TPW_OFS_CMPB_HI: next_state.temp    = wbyte;
        `TPW_OFS_CNT_LO:
        begin
          // a software write to the counter wins over this cycle's step
          next_state.count = {state.temp, wbyte};
          if ({state.temp, wbyte} == `TPW_BOTTOM)
            next_state.down = 1'b0;
        end
        `TPW_OFS_CMPA_LO: next_state.cmp_a = {state.temp, wbyte};
        `TPW_OFS_CMPB_LO: next_state.cmp_b = {state.temp, wbyte};
        `TPW_OFS_MASK:    next_state.mask  = wbyte & `TPW_IRQ_BITS_MASK;
        default:          next_state.mask  = state.mask;
      endcase
    end

    // requests are formed from the values the flags and mask take this edge
    pend = next_state.flags & next_state.mask & {8{global_irq_enable}};
    next_state.irq_req.cmp_a       = pend[`TPW_BIT_CMP_A];
    next_state.irq_req.cmp_b       = pend[`TPW_BIT_CMP_B];
    next_state.irq_req.capture     = pend[`TPW_BIT_CAPTURE];
    next_state.irq_req.t0_overflow = pend[`TPW_BIT_T0_OVF];
    next_state.irq_req.t1_overflow = pend[`TPW_BIT_T1_OVF];
    next_state.irq = |pend;
  end

  // reset is synchronous; every field gets a constant so the block leaves
  // reset stopped, with no pending request and the bus answer at rest
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state.control         <= `TPW_RST_CONTROL;
      state.mask            <= `TPW_RST_MASK;
      state.flags           <= `TPW_RST_FLAGS;
      state.temp            <= 8'h00;
      state.count           <= `TPW_RST_WORD16;
      state.down            <= 1'b0;
      state.cmp_a           <= `TPW_RST_WORD16;
      state.cmp_b           <= `TPW_RST_WORD16;
      state.capture_prev    <= 1'b0;
      state.rsp.readdata    <= 32'h00000000;
      state.rsp.waitrequest <= 1'b1;
      state.irq_req         <= '0;
      state.irq             <= 1'b0;
    end
    else
      state <= next_state;
  end

  // outputs come straight from the state register, no logic after the flops
  assign bus_rsp = state.rsp;
  assign irq_req = state.irq_req;
  assign irq     = state.irq;

endmodule

// file: verilog/tpw_defines.svh
// register offsets, field positions, reset values and counter limits of the timer block
`ifndef TPW_DEFINES_SVH
`define TPW_DEFINES_SVH

`define TPW_OFS_CONTROL   8'h00
`define TPW_OFS_CNT_LO    8'h04
`define TPW_OFS_CNT_HI    8'h08
`define TPW_OFS_CMPA_LO   8'h0c
`define TPW_OFS_CMPA_HI   8'h10
`define TPW_OFS_CMPB_LO   8'h14
`define TPW_OFS_CMPB_HI   8'h18
`define TPW_OFS_MASK      8'h1c
`define TPW_OFS_FLAGS     8'h20

`define TPW_BIT_T1_OVF    7
`define TPW_BIT_CMP_A     6
`define TPW_BIT_CMP_B     5
`define TPW_BIT_CAPTURE   3
`define TPW_BIT_T0_OVF    1
`define TPW_IRQ_BITS_MASK 8'hea

`define TPW_CTRL_MODE_A_LSB 6
`define TPW_CTRL_MODE_B_LSB 4
`define TPW_CTRL_RES_LSB    0

`define TPW_RST_CONTROL   8'h00
`define TPW_RST_MASK      8'h00
`define TPW_RST_FLAGS     8'h00
`define TPW_RST_WORD16    16'h0000

`define TPW_BOTTOM        16'h0000
`define TPW_TOP_8         16'h00ff
`define TPW_TOP_9         16'h01ff
`define TPW_TOP_10        16'h03ff

`define TPW_VEC_CAPTURE   4'h3
`define TPW_VEC_CMP_A     4'h4
`define TPW_VEC_CMP_B     4'h5
`define TPW_VEC_T1_OVF    4'h6
`define TPW_VEC_T0_OVF    4'h7

`endif

// file: verilog/tpw_pkg.sv
// types shared by the timer block and its channel module
package tpw_pkg;

  typedef enum logic [1:0]
  {
    TPW_RES_OFF,
    TPW_RES_8,
    TPW_RES_9,
    TPW_RES_10
  } tpw_res_t;

  typedef enum logic [1:0]
  {
    TPW_OUT_OFF0,
    TPW_OUT_OFF1,
    TPW_OUT_NORMAL,
    TPW_OUT_INVERTED
  } tpw_out_mode_t;

  typedef struct packed
  {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } tpw_bus_req_t;

  typedef struct packed
  {
    logic [31:0] readdata;
    logic        waitrequest;
  } tpw_bus_rsp_t;

  typedef struct packed
  {
    logic t1_overflow;
    logic cmp_a;
    logic cmp_b;
    logic capture;
    logic t0_overflow;
  } tpw_irq_t;

  typedef struct packed
  {
    logic [15:0] active;
    logic        pin;
    logic        pin_oe;
  } tpw_chan_state_t;

  typedef struct packed
  {
    logic [7:0]   control;
    logic [7:0]   mask;
    logic [7:0]   flags;
    logic [7:0]   temp;
    logic [15:0]  count;
    logic         down;
    logic [15:0]  cmp_a;
    logic [15:0]  cmp_b;
    logic         capture_prev;
    tpw_bus_rsp_t rsp;
    tpw_irq_t     irq_req;
    logic         irq;
  } tpw_state_t;

endpackage

// file: verilog/tpw_chan.sv
// one phase-correct pwm channel: buffered compare value, match detect and output pin
`timescale 1ns/1ps
`include "tpw_defines.svh"

module tpw_chan
#(
  parameter int CMP_BITS = 10
)
(
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  run,
  input  wire logic                  at_top,
  input  wire logic                  down,
  input  wire logic [15:0]           count,
  input  wire logic [15:0]           hold,
  input  wire tpw_pkg::tpw_out_mode_t mode,
  output logic                       match,
  output logic                       pin,
  output logic                       pin_oe
);
  import tpw_pkg::*;

  tpw_chan_state_t state;
  tpw_chan_state_t next_state;
  logic [15:0]     cmp_mask;

  initial
  begin
    if (CMP_BITS < 8 || CMP_BITS > 16)
      $error("tpw_chan: CMP_BITS must lie in 8..16");
  end

  assign cmp_mask = 16'((32'h1 << CMP_BITS) - 32'h1);
  // only the low compare bits take part in the match
  assign match    = run && ((count & cmp_mask) == (state.active & cmp_mask));
  assign pin      = state.pin;
  assign pin_oe   = state.pin_oe;

  always_comb
  begin
    next_state = state;
    // the active value only moves at top or while stopped so a write mid-period cannot cut a pulse short
    if (!run || at_top)
      next_state.active = hold & cmp_mask;
    next_state.pin_oe = run && (mode == TPW_OUT_NORMAL || mode == TPW_OUT_INVERTED);
    if (match)
    begin
      case (mode)
        TPW_OUT_NORMAL:   next_state.pin = down;
        TPW_OUT_INVERTED: next_state.pin = !down;
        default:          next_state.pin = state.pin;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state.active <= `TPW_RST_WORD16;
      state.pin    <= 1'b0;
      state.pin_oe <= 1'b0;
    end
    else
      state <= next_state;
  end

endmodule

// file: sim/tpw_sva.sv
// port-level assertions for the pwm timer block
`timescale 1ns/1ps
`include "tpw_defines.svh"

module tpw_sva
  import tpw_pkg::*;
(
  input wire logic         clock,
  input wire logic         reset,
  input wire tpw_bus_req_t bus_req,
  input wire tpw_bus_rsp_t bus_rsp,
  input wire logic         global_irq_enable,
  input wire logic         capture_input_pin,
  input wire logic         t0_overflow_event,
  input wire tpw_irq_t     irq_req,
  input wire logic         irq,
  input wire logic         pwm_out_a,
  input wire logic         pwm_out_a_oe,
  input wire logic         pwm_out_b,
  input wire logic         pwm_out_b_oe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  property p_irq_or;
    irq == (|irq_req);
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq is not the or of requests");

  property p_gie_off;
    !global_irq_enable |=> irq_req == 5'h00;
  endproperty
  a_gie_off: assert property (p_gie_off) else $error("request with global off");

  property p_cmp_a;
    $rose(irq_req.cmp_a) |-> $past(global_irq_enable);
  endproperty
  a_cmp_a: assert property (p_cmp_a) else $error("compare a request ungated");

  property p_cmp_b;
    $rose(irq_req.cmp_b) |-> $past(global_irq_enable);
  endproperty
  a_cmp_b: assert property (p_cmp_b) else $error("compare b request ungated");

  property p_cap;
    $rose(irq_req.capture) |-> $past(global_irq_enable);
  endproperty
  a_cap: assert property (p_cap) else $error("capture request ungated");

  property p_t0;
    $rose(irq_req.t0_overflow) |-> $past(global_irq_enable);
  endproperty
  a_t0: assert property (p_t0) else $error("timer0 request ungated");

  property p_t1;
    $rose(irq_req.t1_overflow) |-> $past(global_irq_enable);
  endproperty
  a_t1: assert property (p_t1) else $error("timer1 request ungated");

  property p_resv;
    bus_req.read && !bus_rsp.waitrequest && bus_req.address == `TPW_OFS_MASK
      |-> (bus_rsp.readdata[7:0] & 8'h15) == 8'h00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved mask bit read as one");
endmodule

bind tpw_top tpw_sva chk_u
(
  .clock             (clock),
  .reset             (reset),
  .bus_req           (bus_req),
  .bus_rsp           (bus_rsp),
  .global_irq_enable (global_irq_enable),
  .capture_input_pin (capture_input_pin),
  .t0_overflow_event (t0_overflow_event),
  .irq_req           (irq_req),
  .irq               (irq),
  .pwm_out_a         (pwm_out_a),
  .pwm_out_a_oe      (pwm_out_a_oe),
  .pwm_out_b         (pwm_out_b),
  .pwm_out_b_oe      (pwm_out_b_oe)
);

// file: sim/tpw_core_model.sv
// processor core model: avalon master and global interrupt enable
`timescale 1ns/1ps

module tpw_core_model
  import tpw_pkg::*;
(
  input  wire logic         clock,
  input  wire tpw_bus_rsp_t bus_rsp,
  output tpw_bus_req_t      bus_req,
  output logic              global_irq_enable
);
  initial
  begin
    bus_req = '0;
    global_irq_enable = 1'b0;
  end

  // request held until waitrequest is sampled low, data taken at that edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clock);
    bus_req <= '{address: a, read: !wr, write: wr, writedata: {24'h000000, d}};
    do @(posedge clock); while (bus_rsp.waitrequest !== 1'b0);
    q = bus_rsp.readdata[7:0];
    bus_req.read <= 1'b0;
    bus_req.write <= 1'b0;
  endtask

  // the staging byte is shared, so interrupts stay off around wide accesses
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    logic [7:0] q;
    global_irq_enable <= 1'b0;
    xfer(1'b1, a + 8'h04, v[15:8], q);
    xfer(1'b1, a, v[7:0], q);
  endtask

  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    global_irq_enable <= 1'b0;
    xfer(1'b0, a, 8'h00, v[7:0]);
    xfer(1'b0, a + 8'h04, 8'h00, v[15:8]);
  endtask
endmodule

// file: sim/tpw_top_tb.sv
// self-checking bench for the pwm timer block
`timescale 1ns/1ps
`include "tpw_defines.svh"

module tpw_top_tb;
  import tpw_pkg::*;
  logic         clock;
  logic         reset;
  logic         cap;
  logic         t0ev;
  tpw_bus_req_t req;
  tpw_bus_rsp_t rsp;
  logic         gie;
  tpw_irq_t     irq_req;
  logic         irq, pa, pa_oe, pb, pb_oe;
  int           errors = 0;
  int           tests_run = 0;
  int           ha, hb;
  logic [15:0]  rnd = 16'h0012;
  logic [15:0]  w, top, v, vb;
  logic [7:0]   q;
  logic [1:0]   ma, mb, rr;

  tpw_top #(.CMP_BITS(10)) dut_u (.clock(clock), .reset(reset), .bus_req(req),
    .bus_rsp(rsp), .global_irq_enable(gie), .capture_input_pin(cap),
    .t0_overflow_event(t0ev), .irq_req(irq_req), .irq(irq), .pwm_out_a(pa),
    .pwm_out_a_oe(pa_oe), .pwm_out_b(pb), .pwm_out_b_oe(pb_oe));
  tpw_core_model core_u (.clock(clock), .bus_rsp(rsp), .bus_req(req),
    .global_irq_enable(gie));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // high time per period: 2v for normal, the rest for inverted
  function automatic logic [15:0] exp_high(input logic [1:0] m, input logic [15:0] c,
                                           input logic [15:0] t);
    return m[0] ? 16'(2 * (t - c)) : 16'(2 * c);
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial
  begin
    repeat (40000) @(posedge clock);
    errors++;
    complete_run;
  end

  initial
  begin
    reset = 1'b1;
    cap = 1'b0;
    t0ev = 1'b0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    core_u.xfer(1'b0, `TPW_OFS_MASK, 8'h00, q);
    check(q, 8'h00);
    core_u.xfer(1'b1, `TPW_OFS_MASK, 8'hff, q);
    core_u.xfer(1'b0, `TPW_OFS_MASK, 8'h00, q);
    check(q, `TPW_IRQ_BITS_MASK);
    core_u.xfer(1'b1, `TPW_OFS_MASK, 8'h00, q);
    core_u.xfer(1'b0, 8'h24, 8'h00, q);
    check(q, 8'h00);
    @(posedge clock);
    t0ev <= 1'b1;
    cap <= 1'b1;
    core_u.global_irq_enable <= 1'b1;
    @(posedge clock);
    t0ev <= 1'b0;
    repeat (2) @(posedge clock);
    check(irq_req, 5'h00);
    core_u.xfer(1'b0, `TPW_OFS_FLAGS, 8'h00, q);
    check(q, 8'h0a);
    core_u.xfer(1'b1, `TPW_OFS_MASK, 8'hff, q);
    repeat (2) @(posedge clock);
    check({irq_req, irq}, 6'b000111);
    core_u.global_irq_enable <= 1'b0;
    repeat (2) @(posedge clock);
    check(irq_req, 5'h00);
    core_u.global_irq_enable <= 1'b1;
    core_u.xfer(1'b1, `TPW_OFS_FLAGS, 8'h02, q);
    repeat (2) @(posedge clock);
    check(irq_req, 5'b00010);
    core_u.xfer(1'b1, `TPW_OFS_FLAGS, 8'h08, q);
    rnd = lfsr(rnd);
    core_u.wr16(`TPW_OFS_CNT_LO, rnd);
    core_u.rd16(`TPW_OFS_CNT_LO, w);
    check(w, rnd);
    // later passes rewrite compares while running, so the hold copy must load at top
    for (int i = 0; i < 4; i++)
    begin
      rr = 2'(1 + i % 3);
      top = (16'h0100 << (rr - 2'd1)) - 16'h0001;
      rnd = lfsr(rnd);
      v = 16'h0001 + rnd % (top - 16'h0001);
      vb = 16'h0001 + (rnd >> 3) % (top - 16'h0001);
      ma = i[1:0];
      mb = ~ma;
      core_u.wr16(`TPW_OFS_CMPA_LO, v);
      core_u.wr16(`TPW_OFS_CMPB_LO, vb);
      core_u.wr16(`TPW_OFS_CNT_LO, 16'h0000);
      core_u.xfer(1'b1, `TPW_OFS_CONTROL, {ma, mb, 2'b00, rr}, q);
      repeat (4 * top) @(posedge clock);
      ha = 0;
      hb = 0;
      repeat (2 * top)
      begin
        @(posedge clock);
        ha += int'(pa === 1'b1);
        hb += int'(pb === 1'b1);
      end
      check(pa_oe, ma[1]);
      check(pb_oe, mb[1]);
      if (ma[1])
        check(ha[15:0], exp_high(ma, v, top));
      if (mb[1])
        check(hb[15:0], exp_high(mb, vb, top));
    end
    core_u.xfer(1'b0, `TPW_OFS_FLAGS, 8'h00, q);
    check(q & 8'he0, 8'he0);
    core_u.global_irq_enable <= 1'b1;
    repeat (2) @(posedge clock);
    check(irq_req[4:2], 3'b111);
    complete_run;
  end
endmodule
